// ### pkg/scan_port_switch_map.vh
// constants shared by the scan port switch design
`ifndef SCAN_PORT_SWITCH_MAP_VH
`define SCAN_PORT_SWITCH_MAP_VH

`define SPS_ADDR_W        10
`define SPS_SYNC_STAGES   2

// reserved global addresses
`define SPS_DISCONNECT_ADDR 10'h3FE
`define SPS_RESET_ADDR      10'h3FD
`define SPS_SYNC_ADDR       10'h3FC

// acknowledgment length in test-clock cycles: one bit pair per address bit
`define SPS_ACK_CYCLES      5'h14
`define SPS_LAST_ADDR_BIT   4'h9

// connect status codes
`define SPS_ST_RESET      2'h0
`define SPS_ST_OFF        2'h1
`define SPS_ST_ON         2'h2
`define SPS_ST_MULTICAST  2'h3

// tracked test access port states
`define TAP_TLR   4'h0
`define TAP_RTI   4'h1
`define TAP_SDRS  4'h2
`define TAP_CDR   4'h3
`define TAP_SDR   4'h4
`define TAP_E1DR  4'h5
`define TAP_PDR   4'h6
`define TAP_E2DR  4'h7
`define TAP_UDR   4'h8
`define TAP_SIRS  4'h9
`define TAP_CIR   4'hA
`define TAP_SIR   4'hB
`define TAP_E1IR  4'hC
`define TAP_PIR   4'hD
`define TAP_E2IR  4'hE
`define TAP_UIR   4'hF

`endif

// ### core/sync_stage.v
// two-flop synchroniser for a group of pin inputs
module sync_stage #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 1'b1
) (
  input  wire             ref_clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta     <= {WIDTH{RESET_VAL}};
      sync_out <= {WIDTH{RESET_VAL}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // sync_stage

// ### core/tap_state_tracker.v
// follows the test access port controller from mode-select at test-clock rises
`include "scan_port_switch_map.vh"

module tap_state_tracker (
  input  wire       ref_clk_in,
  input  wire       rst_b_in,
  input  wire       tck_rise_in,
  input  wire       tms_in,
  output reg  [3:0] tap_state_out
);

  reg [3:0] next_state;

  always @* begin
    case (tap_state_out)
      `TAP_TLR:  next_state = tms_in ? `TAP_TLR  : `TAP_RTI;
      `TAP_RTI:  next_state = tms_in ? `TAP_SDRS : `TAP_RTI;
      `TAP_SDRS: next_state = tms_in ? `TAP_SIRS : `TAP_CDR;
      `TAP_CDR:  next_state = tms_in ? `TAP_E1DR : `TAP_SDR;
      `TAP_SDR:  next_state = tms_in ? `TAP_E1DR : `TAP_SDR;
      `TAP_E1DR: next_state = tms_in ? `TAP_UDR  : `TAP_PDR;
      `TAP_PDR:  next_state = tms_in ? `TAP_E2DR : `TAP_PDR;
      `TAP_E2DR: next_state = tms_in ? `TAP_UDR  : `TAP_SDR;
      `TAP_UDR:  next_state = tms_in ? `TAP_SDRS : `TAP_RTI;
      `TAP_SIRS: next_state = tms_in ? `TAP_TLR  : `TAP_CIR;
      `TAP_CIR:  next_state = tms_in ? `TAP_E1IR : `TAP_SIR;
      `TAP_SIR:  next_state = tms_in ? `TAP_E1IR : `TAP_SIR;
      `TAP_E1IR: next_state = tms_in ? `TAP_UIR  : `TAP_PIR;
      `TAP_PIR:  next_state = tms_in ? `TAP_E2IR : `TAP_PIR;
      `TAP_E2IR: next_state = tms_in ? `TAP_UIR  : `TAP_SIR;
      `TAP_UIR:  next_state = tms_in ? `TAP_SDRS : `TAP_RTI;
      default:   next_state = `TAP_TLR;
    endcase
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tap_state_out <= `TAP_TLR;
    end else if (tck_rise_in) begin
      tap_state_out <= next_state;
    end
  end

endmodule // tap_state_tracker

// ### core/scan_port_switch.v
// addressable switch between a primary and a secondary test access port
// Operation
// - test clock always passed to secondary
// - power-up enters reset, ports disconnected
// - test reset always passed to secondary
// - connected paths are combinational, no retiming
// - disconnected data outputs float except acknowledgment
// - disconnect freezes secondary mode-select level
// - reset condition drives secondary mode-select high
// - shadow accepted only in four stable states
// - ten-bit address compare, three reserved
// - match acknowledges address, then connects
// - mismatch disconnects at once, no acknowledgment
// - global disconnect address acts as mismatch
// - global reset address enters reset condition
// - sync address gives multicast, data-out floats
// - sync address valid only in pause states
// - bypass low connects asynchronously, overriding resets
// - bypass low ignores shadow protocols
// - connected output low whenever ports connected
// - bypass with reset forces mode-select high
// - reset release under bypass resumes bypass
// - mode-select static during protocol; status after ack
// - hard error disconnects, mode-select held
// - sample on rising, acknowledge on falling edge
// - test reset asynchronously restores power-up state
// - address most significant first, synchronous changes
`include "scan_port_switch_map.vh"

module scan_port_switch #(
  parameter ADDR_W = `SPS_ADDR_W
) (
  input  wire              ref_clk_in,
  input  wire              rst_b_in,
  input  wire              primary_test_clock_in,
  input  wire              primary_test_data_in,
  input  wire              primary_test_mode_select_in,
  input  wire              primary_test_reset_n_in,
  input  wire              secondary_test_data_in,
  input  wire              force_connect_n_in,
  input  wire [ADDR_W-1:0] board_address_inputs_in,
  output wire              primary_test_data_out,
  output wire              primary_test_data_oe_out,
  output wire              secondary_test_clock_out,
  output wire              secondary_test_data_out,
  output wire              secondary_test_data_oe_out,
  output wire              secondary_test_mode_select_out,
  output wire              secondary_test_reset_n_out,
  output wire              connected_n_out
);

  // receiver states
  localparam RX_IDLE = 2'h0;
  localparam RX_ADDR = 2'h1;
  localparam RX_END  = 2'h2;
  localparam RX_ACK  = 2'h3;

  // internal state clears on either reset; both act without the clock
  wire core_rst_b = rst_b_in & primary_test_reset_n_in;

  // pin inputs brought into the reference clock domain
  wire [ADDR_W+3:0] raw_pins;
  wire [ADDR_W+3:0] sync_pins;

  assign raw_pins = {board_address_inputs_in, force_connect_n_in, primary_test_mode_select_in,
                     primary_test_data_in, primary_test_clock_in};

  sync_stage #(
    .WIDTH     (ADDR_W + 4),
    .RESET_VAL (1'b1)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (core_rst_b),
    .async_in   (raw_pins),
    .sync_out   (sync_pins)
  );

  wire              s_tck   = sync_pins[0];
  wire              s_tdi   = sync_pins[1];
  wire              s_tms   = sync_pins[2];
  wire              s_byp_n = sync_pins[3];
  wire [ADDR_W-1:0] s_addr  = sync_pins[ADDR_W+3:4];

  // test clock edge detection
  reg  tck_d;
  wire tck_rise = s_tck & ~tck_d;
  wire tck_fall = ~s_tck & tck_d;

  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      tck_d <= 1'b1;
    end else begin
      tck_d <= s_tck;
    end
  end

  // tracked controller state of the primary port
  wire [3:0] tap_state;

  tap_state_tracker u_tap (
    .ref_clk_in    (ref_clk_in),
    .rst_b_in      (core_rst_b),
    .tck_rise_in   (tck_rise),
    .tms_in        (s_tms),
    .tap_state_out (tap_state)
  );

  wire in_pause = (tap_state == `TAP_PDR) || (tap_state == `TAP_PIR);
  wire may_accept = (tap_state == `TAP_TLR) || (tap_state == `TAP_RTI) || in_pause;
  wire shadow_en = s_byp_n;

  // connect status and receiver registers
  reg [1:0]        status;
  reg [1:0]        rx_state;
  reg [1:0]        next_rx_state;
  reg [1:0]        next_status;
  reg              first_bit;
  reg              half;
  reg              prev_tdi;
  reg              frame_tms;
  reg [3:0]        bit_cnt;
  reg [ADDR_W-1:0] rx_addr;
  reg [ADDR_W-1:0] ack_sh;
  reg [4:0]        ack_cnt;
  reg              ack_bit;
  reg              ack_oe;
  reg              held_tms;

  // decode of a completed address
  reg [1:0] decode_rx_state;
  reg [1:0] decode_status;

  always @* begin
    decode_rx_state = RX_IDLE;
    decode_status   = status;
    if (rx_addr == `SPS_RESET_ADDR) begin
      decode_status = `SPS_ST_RESET;
    end else if (rx_addr == `SPS_DISCONNECT_ADDR) begin
      decode_status = `SPS_ST_OFF;
    end else if (rx_addr == `SPS_SYNC_ADDR) begin
      if (in_pause) begin
        decode_status = `SPS_ST_MULTICAST;
      end
    end else if (rx_addr == s_addr) begin
      decode_rx_state = RX_ACK;
    end else begin
      decode_status = `SPS_ST_OFF;
    end
  end

  // receiver next state on a rising test-clock edge
  always @* begin
    next_rx_state = rx_state;
    next_status   = status;
    case (rx_state)
      RX_IDLE: begin
        if (may_accept && !prev_tdi && !s_tdi) begin
          next_rx_state = RX_ADDR;
        end
      end
      RX_ADDR: begin
        if (s_tms != frame_tms || !may_accept) begin
          next_rx_state = RX_IDLE;
        end else if (half && first_bit == s_tdi) begin
          next_rx_state = RX_IDLE;
          next_status   = `SPS_ST_OFF;
        end else if (half && bit_cnt == `SPS_LAST_ADDR_BIT) begin
          next_rx_state = RX_END;
        end
      end
      RX_END: begin
        if (s_tms != frame_tms || !may_accept) begin
          next_rx_state = RX_IDLE;
        end else if (half && !(first_bit && s_tdi)) begin
          next_rx_state = RX_IDLE;
          next_status   = `SPS_ST_OFF;
        end
      end
      RX_ACK: begin
        next_rx_state = RX_ACK;
      end
      default: begin
        next_rx_state = RX_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      status    <= `SPS_ST_RESET;
      rx_state  <= RX_IDLE;
      first_bit <= 1'b0;
      half      <= 1'b0;
      prev_tdi  <= 1'b1;
      frame_tms <= 1'b1;
      bit_cnt   <= 4'h0;
      rx_addr   <= {ADDR_W{1'b0}};
      ack_sh    <= {ADDR_W{1'b0}};
      ack_cnt   <= 5'h00;
      ack_bit   <= 1'b1;
      ack_oe    <= 1'b0;
    end else if (!shadow_en) begin
      // bypass: any frame in progress is dropped
      rx_state <= RX_IDLE;
      half     <= 1'b0;
      prev_tdi <= 1'b1;
      ack_oe   <= 1'b0;
      ack_cnt  <= 5'h00;
    end else if (tck_rise && rx_state != RX_ACK) begin
      // data sampled on the rising test-clock edge
      prev_tdi <= s_tdi;
      rx_state <= next_rx_state;
      status   <= next_status;
      case (rx_state)
        RX_IDLE: begin
          half      <= 1'b0;
          bit_cnt   <= 4'h0;
          frame_tms <= s_tms;
        end
        RX_ADDR: begin
          half <= ~half;
          if (!half) begin
            first_bit <= s_tdi;
          end else begin
            rx_addr <= {rx_addr[ADDR_W-2:0], first_bit};
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        RX_END: begin
          half <= ~half;
          if (!half) begin
            first_bit <= s_tdi;
          end else if (first_bit && s_tdi) begin
            rx_state <= decode_rx_state;
            status   <= decode_status;
            ack_sh   <= s_addr;
            ack_cnt  <= 5'h00;
            prev_tdi <= 1'b1;
          end
        end
        default: begin
          half <= 1'b0;
        end
      endcase
    end else if (tck_fall && rx_state == RX_ACK) begin
      // acknowledgment changes on the falling edge, address first then inverse
      if (ack_cnt < `SPS_ACK_CYCLES) begin
        ack_oe  <= 1'b1;
        ack_bit <= ack_sh[ADDR_W-1] ^ ack_cnt[0];
        ack_cnt <= ack_cnt + 5'h01;
        if (ack_cnt[0]) begin
          ack_sh <= {ack_sh[ADDR_W-2:0], 1'b0};
        end
      end else begin
        ack_oe   <= 1'b0;
        status   <= `SPS_ST_ON;
        rx_state <= RX_IDLE;
        half     <= 1'b0;
      end
    end
  end

  // connect status as the pass-through paths see it; bypass acts without the clock
  wire bypass_on = ~force_connect_n_in;
  wire st_reset  = (status == `SPS_ST_RESET);
  wire st_on     = (status == `SPS_ST_ON);
  wire st_multi  = (status == `SPS_ST_MULTICAST);
  wire data_conn = bypass_on || st_on;
  wire tms_conn  = data_conn || st_multi;

  // clocked view of the connection, from the synchronised bypass only
  wire sync_bypass = ~s_byp_n;
  wire sync_conn   = sync_bypass || st_on || st_multi;

  // last mode-select level kept while the secondary port is driven from the primary
  always @(posedge ref_clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      held_tms <= 1'b1;
    end else if (st_reset && !sync_bypass) begin
      held_tms <= 1'b1;
    end else if (sync_conn) begin
      held_tms <= s_tms;
    end
  end

  // secondary mode-select source
  reg sec_tms;

  always @* begin
    if (bypass_on) begin
      if (!primary_test_reset_n_in) begin
        sec_tms = 1'b1;
      end else begin
        sec_tms = primary_test_mode_select_in;
      end
    end else if (st_reset) begin
      sec_tms = 1'b1;
    end else if (tms_conn) begin
      sec_tms = primary_test_mode_select_in;
    end else begin
      sec_tms = held_tms;
    end
  end

  // primary data-out: return path while connected outside multicast, else the acknowledgment
  reg pri_tdo;
  reg pri_tdo_oe;

  always @* begin
    if (data_conn) begin
      pri_tdo    = secondary_test_data_in;
      pri_tdo_oe = 1'b1;
    end else begin
      pri_tdo    = ack_bit;
      pri_tdo_oe = ack_oe;
    end
  end

  // pass-through paths, combinational while connected
  assign secondary_test_clock_out   = primary_test_clock_in;
  assign secondary_test_reset_n_out = primary_test_reset_n_in;

  assign secondary_test_data_out    = primary_test_data_in;
  assign secondary_test_data_oe_out = tms_conn;

  assign primary_test_data_out          = pri_tdo;
  assign primary_test_data_oe_out       = pri_tdo_oe;
  assign secondary_test_mode_select_out = sec_tms;
  assign connected_n_out                = ~tms_conn;

endmodule // scan_port_switch

// ### sim/scan_port_switch_asserts.sv
// pin-level assertions for the scan port switch
module scan_port_switch_asserts (
  input logic ref_clk_in,
  input logic rst_b_in,
  input logic primary_test_clock_in,
  input logic primary_test_data_in,
  input logic primary_test_mode_select_in,
  input logic primary_test_reset_n_in,
  input logic secondary_test_data_in,
  input logic force_connect_n_in,
  input logic primary_test_data_out,
  input logic primary_test_data_oe_out,
  input logic secondary_test_clock_out,
  input logic secondary_test_data_out,
  input logic secondary_test_data_oe_out,
  input logic secondary_test_mode_select_out,
  input logic secondary_test_reset_n_out,
  input logic connected_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  AST_PASS_THROUGH: assert property (
    secondary_test_clock_out == primary_test_clock_in && secondary_test_reset_n_out == primary_test_reset_n_in)
    else $error("clock or reset not passed");
  AST_BYP_CONNECT: assert property (
    !force_connect_n_in |-> !connected_n_out && secondary_test_data_oe_out && primary_test_data_oe_out)
    else $error("bypass not connected");
  AST_FORCED_CONNECT_IN_RESET_STATUS_MS: assert property (
    !force_connect_n_in && !primary_test_reset_n_in |-> secondary_test_mode_select_out)
    else $error("mode select not forced high");
  AST_TRST_OFF: assert property (
    force_connect_n_in && !primary_test_reset_n_in |-> connected_n_out && secondary_test_mode_select_out
      && !primary_test_data_oe_out && !secondary_test_data_oe_out)
    else $error("test reset did not disconnect");
  AST_CONN_PATHS: assert property (
    !connected_n_out && primary_test_reset_n_in |-> secondary_test_data_out == primary_test_data_in
      && secondary_test_mode_select_out == primary_test_mode_select_in)
    else $error("forward paths differ");
  AST_CON_OE: assert property (connected_n_out == !secondary_test_data_oe_out)
    else $error("connect flag and enable disagree");
  AST_RETURN_PATH: assert property (
    primary_test_data_oe_out && !connected_n_out |-> primary_test_data_out == secondary_test_data_in)
    else $error("return path differs");
  AST_ACK_ON_FALL: assert property (
    $changed(primary_test_data_out) && connected_n_out && primary_test_data_oe_out
      && $past(primary_test_data_oe_out) |-> !$past(primary_test_clock_in))
    else $error("ack bit changed outside low clock");
endmodule // scan_port_switch_asserts

bind scan_port_switch scan_port_switch_asserts scan_port_switch_asserts_inst (
  .ref_clk_in, .rst_b_in, .primary_test_clock_in, .primary_test_data_in, .primary_test_mode_select_in,
  .primary_test_reset_n_in, .secondary_test_data_in, .force_connect_n_in, .primary_test_data_out,
  .primary_test_data_oe_out, .secondary_test_clock_out, .secondary_test_data_out, .secondary_test_data_oe_out,
  .secondary_test_mode_select_out, .secondary_test_reset_n_out, .connected_n_out
);

// ### sim/sec_tap_model.sv
// board-level test port stand-in on the secondary side
module sec_tap_model (
  input  wire logic tck_in,
  input  wire logic tdi_in,
  input  wire logic tdi_oe_in,
  output logic      tdo_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_bit = 1'b0;
  initial tdo_out = 1'b1;
  // undriven input: take a changing value, never the stale one
  always @(posedge tck_in) last_bit <= tdi_oe_in ? tdi_in : ~last_bit;
  always @(negedge tck_in) tdo_out <= ~last_bit;
endmodule // sec_tap_model

// ### sim/tb_top.sv
// self-checking bench for the scan port switch
`include "scan_port_switch_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, primary_test_clock_in = 1'b1, primary_test_data_in = 1'b1;
  logic primary_test_mode_select_in = 1'b1, primary_test_reset_n_in = 1'b1, force_connect_n_in = 1'b1;
  logic [9:0] board_address_inputs_in = 10'h000;
  wire primary_test_data_out, primary_test_data_oe_out, secondary_test_clock_out, secondary_test_data_out;
  wire secondary_test_data_oe_out, secondary_test_mode_select_out, secondary_test_reset_n_out, connected_n_out;
  wire secondary_test_data_in;
  wire [3:0] pins = {connected_n_out, secondary_test_data_oe_out, primary_test_data_oe_out,
                     secondary_test_mode_select_out};
  int mismatches = 0, total_checks = 0, st = 0, tap_kind = 0;
  logic frz = 1'b1, smp_d, smp_oe;

  scan_port_switch scan_port_switch_inst (.ref_clk_in, .rst_b_in, .primary_test_clock_in, .primary_test_data_in,
    .primary_test_mode_select_in, .primary_test_reset_n_in, .secondary_test_data_in, .force_connect_n_in,
    .board_address_inputs_in, .primary_test_data_out, .primary_test_data_oe_out, .secondary_test_clock_out,
    .secondary_test_data_out, .secondary_test_data_oe_out, .secondary_test_mode_select_out,
    .secondary_test_reset_n_out, .connected_n_out);
  sec_tap_model sec_tap_model_inst (.tck_in(secondary_test_clock_out), .tdi_in(secondary_test_data_out),
    .tdi_oe_in(secondary_test_data_oe_out), .tdo_out(secondary_test_data_in));

  always #5 ref_clk_in = ~ref_clk_in;

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one test clock period; samples the return line just before the fall
  task automatic tck(input logic d, input logic m);
    @(negedge ref_clk_in);
    smp_d = primary_test_data_out;
    smp_oe = primary_test_data_oe_out;
    primary_test_clock_in = 1'b0;
    primary_test_data_in = d;
    primary_test_mode_select_in = m;
    repeat (4) @(negedge ref_clk_in);
    primary_test_clock_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
  endtask

  task automatic look();
    logic [3:0] e;
    #1;
    if (!force_connect_n_in) e = {3'h3, primary_test_mode_select_in | ~primary_test_reset_n_in};
    else if (st == 0) e = 4'h9;
    else if (st == 1) e = {3'h4, frz};
    else e = {2'h1, st == 2, primary_test_mode_select_in};
    chk(pins, e);
    chk(secondary_test_clock_out, primary_test_clock_in);
    chk(secondary_test_reset_n_out, primary_test_reset_n_in);
    if (!e[3]) chk(secondary_test_data_out, primary_test_data_in);
    if (e[1] && !e[3]) chk(primary_test_data_out, secondary_test_data_in);
  endtask

  task automatic frame(input logic [9:0] a, input logic bad);
    logic [19:0] ackv, oev, expa;
    logic        m;
    int          nst;
    m = primary_test_mode_select_in;
    nst = st;
    tck(1'b0, m);
    tck(1'b0, m);
    for (int i = 9; i >= 0; i--) begin
      tck(a[i], m);
      tck(~a[i] ^ bad, m);
      expa = {expa[17:0], a[i], ~a[i]};
    end
    tck(1'b1, m);
    tck(1'b1, m);
    if (force_connect_n_in && tap_kind != 2) begin
      if (bad) nst = 1;
      else if (a == board_address_inputs_in) nst = 2;
      else if (a == `SPS_RESET_ADDR) nst = 0;
      else if (a == `SPS_SYNC_ADDR) nst = (tap_kind == 1) ? 3 : st;
      else nst = 1;
    end
    if (nst == 1 && st != 1) frz = (st == 0) ? 1'b1 : m;
    for (int k = 0; k < 21; k++) begin
      tck(1'b1, m);
      ackv = {ackv[18:0], smp_d};
      oev = {oev[18:0], smp_oe};
    end
    chk(oev, (nst == 2 || !force_connect_n_in) ? 20'hFFFFF : 20'h00000);
    if (nst == 2 && st != 2) chk(ackv, expa);
    st = nst;
    repeat (2) @(negedge ref_clk_in);
    look();
  endtask

  initial begin
    #200us;
    mismatches++;
    final_report();
  end

  initial begin
    void'($urandom(76718));
    board_address_inputs_in = 10'($urandom % 1020);
    repeat (8) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    look();
    frame(board_address_inputs_in, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk_in);
      primary_test_data_in = 1'($urandom);
      look();
    end
    frame(board_address_inputs_in ^ 10'h001, 1'b0);
    @(negedge ref_clk_in);
    primary_test_mode_select_in = ~frz;
    look();
    @(negedge ref_clk_in);
    primary_test_mode_select_in = 1'b0;
    frame(board_address_inputs_in, 1'b0);
    frame(`SPS_DISCONNECT_ADDR, 1'b0);
    frame(`SPS_RESET_ADDR, 1'b0);
    frame(`SPS_SYNC_ADDR, 1'b0);
    for (int i = 0; i < 4; i++) tck(1'b1, ~i[0]);
    tap_kind = 1;
    frame(`SPS_SYNC_ADDR, 1'b0);
    tck(1'b1, 1'b1);
    tck(1'b1, 1'b0);
    tap_kind = 2;
    frame(board_address_inputs_in, 1'b0);
    repeat (5) tck(1'b1, 1'b1);
    tap_kind = 0;
    frame(board_address_inputs_in, 1'b1);
    @(negedge ref_clk_in);
    force_connect_n_in = 1'b0;
    look();
    frame(board_address_inputs_in ^ 10'h001, 1'b0);
    @(negedge ref_clk_in);
    primary_test_reset_n_in = 1'b0;
    rst_b_in = 1'b0;
    st = 0;
    repeat (5) tck(1'b1, 1'b0);
    look();
    rst_b_in = 1'b1;
    repeat (2) tck(1'b1, 1'b0);
    look();
    primary_test_reset_n_in = 1'b1;
    look();
    primary_test_reset_n_in = 1'b0;
    force_connect_n_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    look();
    primary_test_reset_n_in = 1'b1;
    look();
    final_report();
  end
endmodule // tb_top
